// File: rtl/mtp_pkg.sv
package mtp_pkg;
  // Timing
  localparam int CLK_MHZ     = 100;
  localparam int DEB_TIME_US = 1000;
  localparam int DEB_CYCLES  = DEB_TIME_US * CLK_MHZ;

  // Interface selector geometry
  localparam int N_CI    = 24;
  localparam int N_CI_LO = 12;
  localparam int SEL_W   = 4;

  // Pushbutton indices
  localparam int BTN_RST  = 0;
  localparam int BTN_GO   = 1;
  localparam int BTN_STEP = 2;
  localparam int BTN_THRM = 3;
  localparam int BTN_OTC  = 4;
  localparam int BTN_SETC = 5;
  localparam int BTN_RSTC = 6;
  localparam int N_BTN    = 7;

  // Unit state and mode selector codes
  localparam logic [1:0] STATE_ZERO = 2'h0;
  localparam logic [1:0] MODE_CMD   = 2'h0;
  localparam logic [1:0] MODE_BYTE  = 2'h1;
  localparam logic [1:0] MODE_CONT  = 2'h2;

  // Switch field positions (bit 0 is the leftmost switch)
  localparam int ST_LO   = 2;
  localparam int ST_HI   = 3;
  localparam int CON_LO  = 4;
  localparam int CON_HI  = 7;
  localparam int IO_CONTROL_ELEMENT_LO = 5;
  localparam int IO_CONTROL_ELEMENT_HI = 7;

  // Parity position value after a configuration reset
  localparam logic PAR_RESET = 1'h1;

  typedef struct packed {
    logic       par;
    logic [0:7] bits;
  } mtp_byte_t;

  typedef struct packed {
    logic addr;
    logic sel;
    logic cmd;
    logic srv;
    logic sup;
  } mtp_ctl_t;

  typedef struct packed {
    logic addr_out;
    logic sel_out;
    logic hold_out;
    logic cmd_out;
    logic srv_out;
    logic sup_out;
  } mtp_tags_t;

  typedef struct packed {
    mtp_tags_t tags;
    mtp_byte_t data;
  } mtp_word_t;

  typedef struct packed {
    logic       par_st;
    logic [1:0] state;
    logic       par_rest;
    logic [3:0] connect_bits;
    logic [2:0] io_control_element;
  } mtp_cfg_t;

  localparam mtp_cfg_t CFG_RESET = '{PAR_RESET, 2'h0, PAR_RESET, 4'h0, 3'h0};

  typedef struct packed {
    logic en_attn;
    logic en_if;
    logic err_rpt;
  } mtp_ci_t;

  typedef struct packed {
    logic      test;
    logic      thermal;
    logic      out_of_tolerance_check;
    logic      element_check_pulse;
    logic      cfg_par;
    logic      init_sel;
    logic      write_mode;
    logic      bus_out_gate;
    logic      addr_out_gate;
    mtp_ci_t   ci_lo;
    mtp_ci_t   ci_hi;
    mtp_byte_t bus_in;
    mtp_cfg_t  cfg;
  } mtp_ind_t;
endpackage

// File: rtl/mtp_maintenance_panel.sv
// Notes on behaviour
// - Test at state zero detaches, enables controls
// - Test entered at nonzero state stays attached
// - Test controls act only when detached, state zero
// - Lamp test forces every indicator on
// - Thermal reset clears only at normal temperature
// - Out-of-tolerance button pulses check, holds sense bit
// - Two selectors route interface latches to display
// - Panel reset clears panel, readies initial selection
// - Start launches transfer of the selected mode
// - Single steps per request; continuous runs freely
// - Address and bus-out switches: parity plus 0-7
// - Control selections encoded into tag pattern
// - Single command sends one control sequence
// - Single byte moves one byte per start
// - Continuous repeats until reset or mode change
// - Set config loads state, connect, element bits
// - Reset config resets unit, parity ones
// - Config register: state, connect, element bits
// - Parity indicator shows bad config parity
`timescale 1ns/1ps
`default_nettype none
module mtp_maintenance_panel
  import mtp_pkg::*;
#(
  parameter int DEB_CNT = DEB_CYCLES
) (
  input  wire logic            mclk_i,
  input  wire logic            rst_b_i,
  input  wire logic            ce_i,
  input  wire logic            test_sel_i,
  input  wire logic [1:0]      unit_state_i,
  input  wire logic            lamp_test_i,
  input  wire logic [N_BTN-1:0] btn_i,
  input  wire logic            over_temp_i,
  input  wire logic            clock_single_i,
  input  wire logic [1:0]      mode_i,
  input  wire mtp_byte_t       addr_sw_i,
  input  wire mtp_byte_t       bus_out_sw_i,
  input  wire mtp_ctl_t        ctl_out_sw_i,
  input  wire logic [SEL_W-1:0] ci_sel_lo_i,
  input  wire logic [SEL_W-1:0] ci_sel_hi_i,
  input  wire mtp_ci_t         ci_latch_i [N_CI],
  input  wire logic            in_valid_i,
  input  wire mtp_byte_t       in_byte_i,
  input  wire logic            out_ready_i,
  output logic                 out_valid_o,
  output mtp_word_t            out_word_o,
  output logic                 detached_o,
  output logic                 unit_clk_step_o,
  output logic                 unit_reset_o,
  output logic                 init_prep_o,
  output logic                 elc_pulse_o,
  output logic                 sense2_bit7_o,
  output mtp_cfg_t             cfg_o,
  output mtp_ind_t             ind_o
);
  localparam int CW = $clog2(DEB_CNT + 1);
  localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CNT - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_ONE, ST_CONT} mtp_fsm_t;

  logic [N_BTN-1:0] sync1_reg, sync2_reg, lvl_reg, lvl_d_reg;
  logic [N_BTN-1:0] press;
  logic [CW-1:0]    cnt_reg [N_BTN];
  logic             test_d_reg, detached_reg, ctl_en;
  logic             p_rst, p_go, p_step, p_thrm, p_otc, p_setc, p_rstc;
  mtp_fsm_t         fsm_reg;
  mtp_word_t        word_next, word_reg;
  logic             push, in_ready_reg;
  logic             hd_valid_reg, sp_valid_reg;
  mtp_word_t        hd_reg, sp_reg;
  logic             thermal_reg, elc_ind_reg, init_sel_reg, write_reg;
  logic             bo_gate_reg, ao_gate_reg;
  mtp_byte_t        bus_in_reg;
  mtp_cfg_t         cfg_reg, cfg_next;
  mtp_ind_t         ind_next;
  mtp_ci_t          ci_lo, ci_hi;

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (ce_i) begin
      sync1_reg <= btn_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Debounce: level follows input only after it stays put DEB_CNT cycles
  for (genvar b = 0; b < N_BTN; b++) begin : g_deb
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        cnt_reg[b] <= '0;
        lvl_reg[b] <= 1'b0;
      end else if (ce_i) begin
        if (sync2_reg[b] == lvl_reg[b]) begin
          cnt_reg[b] <= '0;
        end else if (cnt_reg[b] == DEB_LAST) begin
          cnt_reg[b] <= '0;
          lvl_reg[b] <= sync2_reg[b];
        end else begin
          cnt_reg[b] <= cnt_reg[b] + 1'b1;
        end
      end
    end
  end

  // Edge memory for one pulse per press
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      lvl_d_reg <= '0;
    end else if (ce_i) begin
      lvl_d_reg <= lvl_reg;
    end
  end

  // Press pulses, test-only buttons gated by the enable condition
  assign press  = lvl_reg & ~lvl_d_reg;
  assign ctl_en = detached_reg && test_sel_i && (unit_state_i == STATE_ZERO);
  assign p_rst  = press[BTN_RST] && ctl_en;
  assign p_go   = press[BTN_GO] && ctl_en;
  assign p_step = press[BTN_STEP] && ctl_en;
  assign p_setc = press[BTN_SETC] && ctl_en;
  assign p_rstc = press[BTN_RSTC] && ctl_en;
  assign p_thrm = press[BTN_THRM];
  assign p_otc  = press[BTN_OTC];

  // Isolation: only a move into test while at state zero detaches
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      test_d_reg   <= 1'b0;
      detached_reg <= 1'b0;
    end else if (ce_i) begin
      test_d_reg <= test_sel_i;
      if (!test_sel_i) begin
        detached_reg <= 1'b0;
      end else if (!test_d_reg && unit_state_i == STATE_ZERO) begin
        detached_reg <= 1'b1;
      end
    end
  end

  // Unit clock: free running unless single stepping while detached
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      unit_clk_step_o <= 1'b0;
    end else if (ce_i) begin
      unit_clk_step_o <= (detached_reg && clock_single_i) ? p_step : 1'b1;
    end
  end

  // Word to send: control selections encoded into tags, bytes from switches
  always_comb begin
    word_next = '0;
    if (mode_i == MODE_CMD) begin
      word_next.tags.addr_out = ctl_out_sw_i.addr;
      word_next.tags.sel_out  = ctl_out_sw_i.sel;
      word_next.tags.hold_out = ctl_out_sw_i.sel;
      word_next.tags.cmd_out  = ctl_out_sw_i.cmd;
      word_next.tags.srv_out  = ctl_out_sw_i.srv;
      word_next.tags.sup_out  = ctl_out_sw_i.sup;
      word_next.data = ctl_out_sw_i.addr ? addr_sw_i : bus_out_sw_i;
    end else begin
      word_next.tags.srv_out = 1'b1;
      word_next.data = bus_out_sw_i;
    end
  end

  // Transfer sequencer
  assign push = (fsm_reg != ST_IDLE) && in_ready_reg;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      fsm_reg  <= ST_IDLE;
      word_reg <= '0;
    end else if (ce_i) begin
      unique case (fsm_reg)
        ST_IDLE: begin
          if (p_go) begin
            word_reg <= word_next;
            fsm_reg  <= (mode_i == MODE_CONT) ? ST_CONT : ST_ONE;
          end
        end
        ST_ONE: begin
          if (p_rst || push) begin
            fsm_reg <= ST_IDLE;
          end
        end
        ST_CONT: begin
          if (p_rst || mode_i != MODE_CONT) begin
            fsm_reg <= ST_IDLE;
          end else if (push) begin
            word_reg <= word_next;
          end
        end
      endcase
    end
  end

  // Two-entry skid buffer toward the unit; outputs straight from flops
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || (ce_i && p_rst)) begin
      hd_valid_reg <= 1'b0;
      sp_valid_reg <= 1'b0;
      in_ready_reg <= 1'b1;
      hd_reg       <= '0;
      sp_reg       <= '0;
    end else if (ce_i) begin
      if (!hd_valid_reg || out_ready_i) begin
        hd_valid_reg <= sp_valid_reg || push;
        hd_reg       <= sp_valid_reg ? sp_reg : word_reg;
        sp_valid_reg <= sp_valid_reg && push;
        if (sp_valid_reg) begin
          sp_reg <= word_reg;
        end
        in_ready_reg <= !(sp_valid_reg && push);
      end else if (push) begin
        sp_valid_reg <= 1'b1;
        sp_reg       <= word_reg;
        in_ready_reg <= 1'b0;
      end
    end
  end
  assign out_valid_o = hd_valid_reg;
  assign out_word_o  = hd_reg;

  // Panel control latches and received byte display
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      init_sel_reg <= 1'b0;
      write_reg    <= 1'b0;
      bo_gate_reg  <= 1'b0;
      ao_gate_reg  <= 1'b0;
      bus_in_reg   <= '0;
    end else if (ce_i) begin
      if (in_valid_i) begin
        bus_in_reg <= in_byte_i;
      end
      if (p_rst) begin
        init_sel_reg <= 1'b0;
        write_reg    <= 1'b0;
        bo_gate_reg  <= 1'b0;
        ao_gate_reg  <= 1'b0;
      end else if (fsm_reg == ST_IDLE && p_go) begin
        init_sel_reg <= (mode_i == MODE_CMD) && ctl_out_sw_i.sel;
        write_reg    <= (mode_i != MODE_CMD) || ctl_out_sw_i.cmd;
        ao_gate_reg  <= (mode_i == MODE_CMD) && ctl_out_sw_i.addr;
        bo_gate_reg  <= !((mode_i == MODE_CMD) && ctl_out_sw_i.addr);
      end
    end
  end

  // Reset pulses toward the unit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      unit_reset_o <= 1'b0;
      init_prep_o  <= 1'b0;
    end else if (ce_i) begin
      unit_reset_o <= p_rstc;
      init_prep_o  <= p_rst;
    end else begin
      unit_reset_o <= 1'b0;
      init_prep_o  <= 1'b0;
    end
  end

  // Thermal check latch: event sets, clear only when temperature normal
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      thermal_reg <= 1'b0;
    end else if (ce_i) begin
      if (over_temp_i) begin
        thermal_reg <= 1'b1;
      end else if (p_thrm) begin
        thermal_reg <= 1'b0;
      end
    end
  end

  // Out-of-tolerance simulation: check pulse plus held sense bit
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      elc_pulse_o   <= 1'b0;
      sense2_bit7_o <= 1'b0;
      elc_ind_reg   <= 1'b0;
    end else if (ce_i) begin
      elc_pulse_o   <= p_otc;
      sense2_bit7_o <= lvl_reg[BTN_OTC];
      if (p_otc) begin
        elc_ind_reg <= 1'b1;
      end else if (p_rst) begin
        elc_ind_reg <= 1'b0;
      end
    end else begin
      elc_pulse_o <= 1'b0;
    end
  end

  // Configuration register load from switches, odd parity per group
  always_comb begin
    cfg_next = cfg_reg;
    if (p_rstc) begin
      cfg_next = CFG_RESET;
    end else if (p_setc) begin
      cfg_next.state              = addr_sw_i.bits[ST_LO:ST_HI];
      cfg_next.connect_bits       = addr_sw_i.bits[CON_LO:CON_HI];
      cfg_next.io_control_element = bus_out_sw_i.bits[IO_CONTROL_ELEMENT_LO:IO_CONTROL_ELEMENT_HI];
      cfg_next.par_st   = ~^cfg_next.state;
      cfg_next.par_rest = ~^{cfg_next.connect_bits, cfg_next.io_control_element};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cfg_reg <= CFG_RESET;
    end else if (ce_i) begin
      cfg_reg <= cfg_next;
    end
  end
  assign cfg_o = cfg_reg;

  // Interface selectors pick one latch group each
  always_comb begin
    ci_lo = '0;
    ci_hi = '0;
    if (int'(ci_sel_lo_i) < N_CI_LO) begin
      ci_lo = ci_latch_i[ci_sel_lo_i];
    end
    if (int'(ci_sel_hi_i) < N_CI - N_CI_LO) begin
      ci_hi = ci_latch_i[int'(ci_sel_hi_i) + N_CI_LO];
    end
  end

  // Indicator image, forced on by lamp test
  always_comb begin
    ind_next.test          = ctl_en;
    ind_next.thermal       = thermal_reg;
    ind_next.out_of_tolerance_check           = over_temp_i || lvl_reg[BTN_OTC];
    ind_next.element_check_pulse           = elc_ind_reg;
    ind_next.cfg_par       = !(^{cfg_reg.par_st, cfg_reg.state}) ||
                             !(^{cfg_reg.par_rest, cfg_reg.connect_bits,
                                 cfg_reg.io_control_element});
    ind_next.init_sel      = init_sel_reg;
    ind_next.write_mode    = write_reg;
    ind_next.bus_out_gate  = bo_gate_reg;
    ind_next.addr_out_gate = ao_gate_reg;
    ind_next.ci_lo         = ci_lo;
    ind_next.ci_hi         = ci_hi;
    ind_next.bus_in        = bus_in_reg;
    ind_next.cfg           = cfg_reg;
    if (lamp_test_i) begin
      ind_next = '1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ind_o      <= '0;
      detached_o <= 1'b0;
    end else if (ce_i) begin
      ind_o      <= ind_next;
      detached_o <= ctl_en;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_lamp_all_on: assert property (ce_i && lamp_test_i |=> &ind_o)
    else $error("lamp test did not light all indicators");
  a_detach_on_test: assert property (
    ce_i && test_sel_i && !test_d_reg && unit_state_i == STATE_ZERO |=> detached_reg)
    else $error("unit not detached on test at state zero");
  a_stay_attached: assert property (
    ce_i && test_sel_i && test_d_reg && !detached_reg |=> !detached_reg)
    else $error("unit detached after entering test at nonzero state");
  a_idle_when_off: assert property (
    fsm_reg == ST_IDLE && !ctl_en |=> fsm_reg == ST_IDLE)
    else $error("transfer started with controls disabled");
  // Reset sampled high too: the release edge itself still sees the flop in reset
  a_free_clock: assert property (ce_i && rst_b_i && !clock_single_i |=> unit_clk_step_o)
    else $error("unit clock not running in continuous");
  a_single_step: assert property (
    ce_i && detached_reg && clock_single_i && !p_step |=> !unit_clk_step_o)
    else $error("unit clock stepped without request");
  a_otc_pulse: assert property (ce_i && p_otc |=> elc_pulse_o ##1 !elc_pulse_o)
    else $error("element check pulse wrong length");
  a_thermal_hold: assert property (ce_i && thermal_reg && over_temp_i |=> thermal_reg)
    else $error("thermal check cleared while hot");
  a_cfg_reset: assert property (
    ce_i && p_rstc |=> cfg_reg == CFG_RESET && unit_reset_o)
    else $error("configuration reset incomplete");
  a_one_command: assert property (
    ce_i && fsm_reg == ST_ONE && push |=> fsm_reg == ST_IDLE)
    else $error("single transfer sent more than one word");
  a_cont_stop: assert property (
    ce_i && fsm_reg == ST_CONT && mode_i != MODE_CONT |=> fsm_reg == ST_IDLE)
    else $error("continuous transfer did not stop on mode change");
endmodule // mtp_maintenance_panel
`default_nettype wire

// File: verif/mtp_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the relay unit's channel side: sinks panel words, sources bytes
module mtp_unit_model
  import mtp_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_b_i,
  input  wire logic      stall_i,
  input  wire logic      out_valid_i,
  input  wire mtp_word_t out_word_i,
  output logic           out_ready_o,
  input  wire logic      send_i,
  input  wire mtp_byte_t send_byte_i,
  output logic           in_valid_o,
  output mtp_byte_t      in_byte_o,
  output int             words_o,
  output mtp_word_t      last_o
);
  // Ready follows the stall request so the bench can hold words back
  assign out_ready_o = ~stall_i;

  // Count and keep every word taken at a rising edge with valid and ready high
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      words_o <= 0;
      last_o  <= '0;
    end else if (out_valid_i && out_ready_o) begin
      words_o <= words_o + 1;
      last_o  <= out_word_i;
    end
  end

  // One-cycle byte toward the panel; idle lines toggle so stale data never looks valid
  always_ff @(posedge mclk_i) begin
    in_valid_o <= send_i;
    in_byte_o  <= send_i ? send_byte_i : ~in_byte_o;
  end
endmodule // mtp_unit_model
`default_nettype wire

// File: verif/tb_maintenance_test_panel.sv
`timescale 1ns/1ps
`default_nettype none
module tb_maintenance_test_panel;
  import mtp_pkg::*;
  logic            mclk_i = 1'b0;
  logic            rst_b_i = 1'b0;
  logic            test_sel = 1'b0, lamp = 1'b0, over_temp = 1'b0, single = 1'b0, ce = 1'b1;
  logic            stall = 1'b0, send = 1'b0, out_valid, out_ready, in_valid, detached;
  logic            step, urst, init, element_check_pulse, sense;
  logic [1:0]      ustate = 2'h0, mode = MODE_BYTE;
  logic [N_BTN-1:0] btn = '0;
  logic [SEL_W-1:0] sel_lo = '0, sel_hi = '0;
  mtp_byte_t       addr_sw = '0, bus_sw = '0, send_byte = '0, in_byte;
  mtp_ctl_t        ctl = '0;
  mtp_ci_t         ci_latch [N_CI];
  mtp_word_t       out_word, last, exp_w;
  mtp_cfg_t        cfg, exp_c;
  mtp_ind_t        ind;
  int              words, n0, num_errors = 0, samples_checked = 0;
  int              n_step = 0, n_urst = 0, n_elc = 0, n_init = 0;

  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  mtp_maintenance_panel #(.DEB_CNT(4)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce), .test_sel_i(test_sel),
    .unit_state_i(ustate), .lamp_test_i(lamp), .btn_i(btn), .over_temp_i(over_temp),
    .clock_single_i(single), .mode_i(mode), .addr_sw_i(addr_sw), .bus_out_sw_i(bus_sw),
    .ctl_out_sw_i(ctl), .ci_sel_lo_i(sel_lo), .ci_sel_hi_i(sel_hi),
    .ci_latch_i(ci_latch), .in_valid_i(in_valid), .in_byte_i(in_byte),
    .out_ready_i(out_ready), .out_valid_o(out_valid), .out_word_o(out_word),
    .detached_o(detached), .unit_clk_step_o(step), .unit_reset_o(urst),
    .init_prep_o(init), .elc_pulse_o(element_check_pulse), .sense2_bit7_o(sense), .cfg_o(cfg), .ind_o(ind));

  mtp_unit_model unit (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .stall_i(stall), .out_valid_i(out_valid),
    .out_word_i(out_word), .out_ready_o(out_ready), .send_i(send), .send_byte_i(send_byte),
    .in_valid_o(in_valid), .in_byte_o(in_byte), .words_o(words), .last_o(last));

  // Pulse counters for the one-cycle outputs, sampled mid-cycle where settled
  always @(negedge mclk_i) begin
    if (step) n_step++;
    if (urst) n_urst++;
    if (element_check_pulse) n_elc++;
    if (init) n_init++;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Hold a pushbutton long enough to debounce both edges
  task automatic press(input int i);
    @(posedge mclk_i);
    btn[i] <= 1'b1;
    cyc(10);
    btn[i] <= 1'b0;
    cyc(12);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    cyc(20000);
    num_errors++;
    summarize();
  end

  initial begin
    for (int i = 0; i < N_CI; i++) ci_latch[i] <= mtp_ci_t'(i[2:0]);
    cyc(3);
    rst_b_i <= 1'b1;
    cyc(2);
    chk(cfg, CFG_RESET);
    chk(out_valid, 1'b0);
    done("reset");
    // Test entered at a nonzero state keeps the controls dead
    ustate <= 2'h1;
    cyc(1);
    test_sel <= 1'b1;
    addr_sw <= '{1'b0, 8'h0f};
    cyc(3);
    chk(detached, 1'b0);
    n0 = words;
    press(BTN_SETC);
    press(BTN_GO);
    press(BTN_RST);
    chk(cfg, CFG_RESET);
    chk(words - n0, 0);
    chk(n_init, 0);
    lamp <= 1'b1;
    cyc(3);
    chk(ind, {$bits(mtp_ind_t){1'b1}});
    lamp <= 1'b0;
    done("refused");
    // Interface selectors and received byte display
    sel_lo <= 4'h3;
    sel_hi <= 4'h2;
    send_byte <= '{1'b1, 8'ha5};
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    cyc(3);
    chk(ind.ci_lo, ci_latch[3]);
    chk(ind.ci_hi, ci_latch[14]);
    chk(ind.bus_in, 9'h1a5);
    sel_lo <= 4'hc;
    cyc(3);
    chk(ind.ci_lo, 3'h0);
    done("display");
    // Out-of-tolerance and thermal controls work in any state
    n0 = n_elc;
    @(posedge mclk_i);
    btn[BTN_OTC] <= 1'b1;
    cyc(10);
    chk(sense, 1'b1);
    chk(n_elc - n0, 1);
    chk(ind.out_of_tolerance_check, 1'b1);
    chk(ind.element_check_pulse, 1'b1);
    btn[BTN_OTC] <= 1'b0;
    cyc(10);
    chk(sense, 1'b0);
    over_temp <= 1'b1;
    cyc(3);
    press(BTN_THRM);
    chk(ind.thermal, 1'b1);
    over_temp <= 1'b0;
    cyc(3);
    chk(ind.thermal, 1'b1);
    press(BTN_THRM);
    chk(ind.thermal, 1'b0);
    done("otc_thermal");
    // Detach at state zero
    test_sel <= 1'b0;
    ustate <= STATE_ZERO;
    cyc(2);
    test_sel <= 1'b1;
    cyc(3);
    chk(detached, 1'b1);
    single <= 1'b1;
    cyc(3);
    n0 = n_step;
    repeat (3) press(BTN_STEP);
    chk(n_step - n0, 3);
    single <= 1'b0;
    cyc(2);
    n0 = n_step;
    press(BTN_STEP);
    chk(n_step - n0, 23);
    done("clock");
    // Single byte with the unit stalling
    bus_sw <= '{1'b0, 8'h3c};
    stall <= 1'b1;
    n0 = words;
    press(BTN_GO);
    exp_w = '{'{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0}, '{1'b0, 8'h3c}};
    chk(out_valid, 1'b1);
    chk(out_word, exp_w);
    stall <= 1'b0;
    cyc(4);
    chk(words - n0, 1);
    chk(last, exp_w);
    done("single_byte");
    // Single command, every control selection
    mode <= MODE_CMD;
    for (int k = 0; k < 5; k++) begin
      ctl <= mtp_ctl_t'(5'h10 >> k);
      n0 = words;
      press(BTN_GO);
      exp_w.tags = '{ctl.addr, ctl.sel, ctl.sel, ctl.cmd, ctl.srv, ctl.sup};
      exp_w.data = ctl.addr ? addr_sw : bus_sw;
      chk(words - n0, 1);
      chk(ind.addr_out_gate, ctl.addr);
      chk(last, exp_w);
    end
    done("single_cmd");
    // Continuous until a mode change, then until a panel reset
    mode <= MODE_CONT;
    n0 = words;
    press(BTN_GO);
    chk(words - n0 > 4, 1'b1);
    chk(last, {6'h02, 9'h03c});
    mode <= MODE_BYTE;
    cyc(4);
    n0 = words;
    cyc(10);
    chk(words - n0, 0);
    mode <= MODE_CONT;
    press(BTN_GO);
    n0 = n_init;
    press(BTN_RST);
    chk(n_init - n0, 1);
    chk(ind.element_check_pulse, 1'b0);
    chk(ind.bus_out_gate, 1'b0);
    n0 = words;
    cyc(10);
    chk(words - n0, 0);
    done("continuous");
    // Configuration load, parity and reset
    addr_sw <= '{1'b0, 8'h0a};
    bus_sw <= '{1'b0, 8'h05};
    press(BTN_SETC);
    exp_c = '{1'b1, 2'h0, 1'b1, 4'ha, 3'h5};
    chk(cfg, exp_c);
    chk(ind.cfg_par, 1'b0);
    n0 = n_urst;
    press(BTN_RSTC);
    chk(n_urst - n0, 1);
    chk(cfg, CFG_RESET);
    addr_sw <= '{1'b0, 8'h13};
    bus_sw <= '{1'b0, 8'h01};
    press(BTN_SETC);
    exp_c = '{1'b0, 2'h1, 1'b0, 4'h3, 3'h1};
    chk(cfg, exp_c);
    // Clock enable low freezes the panel, so a press is never seen
    ce <= 1'b0;
    press(BTN_RSTC);
    chk(cfg, exp_c);
    chk(n_urst - n0, 1);
    ce <= 1'b1;
    done("config");
    summarize();
  end
endmodule // tb_maintenance_test_panel
`default_nettype wire
